// ===== rtl/dma_map.svh
// register offsets, field positions and request source table of the dma controller
`ifndef DMA_MAP_SVH
`define DMA_MAP_SVH
// word index within a channel, byte address = ch*0x20 + index*4
`define R_CON 3'h0
`define R_REQ 3'h1
`define R_START_A 3'h2
`define R_START_B 3'h3
`define R_PAD 3'h4
`define R_CNT 3'h5
// bus address fields
`define A_STATUS 8
`define A_CH_HI 7
`define A_CH_LO 5
`define A_REG_HI 4
`define A_REG_LO 2
// control word fields, and the force bit of the request word
`define F_EN 15
`define F_BSZ 14
`define F_DIR 13
`define F_HALF 12
`define F_NULLW 11
`define F_AM_HI 5
`define F_AM_LO 4
`define F_MD_HI 1
`define F_MD_LO 0
`define F_FRC 15
// addressing and block modes
`define AM_INC 2'h0
`define AM_FIX 2'h1
`define MD_CONT 2'h0
`define MD_ONE 2'h1
`define MD_CONT_PP 2'h2
`define MD_ONE_PP 2'h3
// request source numbers
`define SRC_EXT_IRQ0 7'h00
`define SRC_IC1 7'h01
`define SRC_OC1 7'h02
`define SRC_TIMER_TWO 7'h07
`define SRC_TIMER_THREE 7'h08
`define SRC_SPI1 7'h0A
`define SRC_U1RX 7'h0B
`define SRC_ADC 7'h0D
`define SRC_CODEC 7'h3C
`define SRC_CANTX 7'h46
`define SRC_DACR 7'h4E
// peripheral data addresses and pointer steps
`define PAD_IC1 16'h0140
`define PAD_OC1_PRI 16'h0182
`define PAD_OC1_SEC 16'h0180
`define PAD_SPI1 16'h0248
`define PAD_U1RX 16'h0226
`define PAD_ADC 16'h0300
`define PAD_CODEC_RX 16'h0290
`define PAD_CODEC_TX 16'h0298
`define PAD_CANTX 16'h0442
`define PAD_DACR 16'h03F6
`define STEP_WORD 16'h0002
`define STEP_BYTE 16'h0001
`endif

// ===== rtl/dma_pkg.sv
// types shared by the dma controller
package dma_pkg;
	typedef struct packed {
		logic en;
		logic bsz;
		logic dir;
		logic half;
		logic nullw;
		logic [1:0] amode;
		logic [1:0] mode;
	} con_t;
	typedef struct packed {
		con_t con;
		logic frc;
		logic [6:0] src;
		logic [15:0] start_a;
		logic [15:0] start_b;
		logic [15:0] pad;
		logic [15:0] ptr;
		logic [9:0] cnt;
		logic [9:0] done;
		logic pp;
		logic pend;
	} chan_t;
	typedef enum logic [2:0] {S_IDLE = 3'h1, S_RD = 3'h2, S_WR = 3'h4} xfer_st_t;
	typedef struct packed {
		logic req;
		logic we;
		logic bsz;
		logic ram;
		logic [15:0] adr;
		logic [15:0] dat;
	} dbus_t;
	typedef struct packed {
		chan_t [7:0] ch;
		xfer_st_t st;
		logic [2:0] cur;
		logic [127:0] irq_prev;
		dbus_t bus;
		logic [7:0] irq;
		logic ack;
		logic [31:0] rdat;
	} state_t;
endpackage

// ===== rtl/periph_dma.sv
// eight channel peripheral dma controller with wishbone register slave
`timescale 1ns/100ps
`include "dma_map.svh"
module periph_dma (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [8:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// peripheral requests, same clock domain
	input wire logic [127:0] periph_irq_in,
	input wire logic [15:0] periph_ram_ofs_in,
	// dedicated transfer bus
	output dma_pkg::dbus_t dbus_out,
	input wire logic [15:0] dbus_rdata_in,
	input wire logic dbus_ack_in,
	// per channel completion requests
	output logic [7:0] irq_out
);
	dma_pkg::state_t s_r;
	dma_pkg::state_t s_nxt;
	dma_pkg::chan_t k;
	logic [127:0] rise;
	logic [7:0] want;
	logic [7:0] en_v;
	logic [7:0] pp_v;
	logic [2:0] c, g, lw;
	logic [15:0] v;
	logic [15:0] a;
	logic [16:0] t;
	logic wr_done, blk_end, frc_set;

	function automatic logic [15:0] merge(logic [15:0] o, logic [31:0] d, logic [3:0] b);
		merge = {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
	endfunction

	function automatic logic [2:0] lowest(logic [7:0] w);
		lowest = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (w[i]) begin
				lowest = 3'(i);
			end
		end
	endfunction

	function automatic logic [15:0] con_rd(dma_pkg::con_t x);
		con_rd = 16'h0000;
		con_rd[`F_EN] = x.en;
		con_rd[`F_BSZ] = x.bsz;
		con_rd[`F_DIR] = x.dir;
		con_rd[`F_HALF] = x.half;
		con_rd[`F_NULLW] = x.nullw;
		con_rd[`F_AM_HI:`F_AM_LO] = x.amode;
		con_rd[`F_MD_HI:`F_MD_LO] = x.mode;
	endfunction

	function automatic dma_pkg::con_t con_wr(logic [15:0] d);
		con_wr.en = d[`F_EN];
		con_wr.bsz = d[`F_BSZ];
		con_wr.dir = d[`F_DIR];
		con_wr.half = d[`F_HALF];
		con_wr.nullw = d[`F_NULLW];
		con_wr.amode = d[`F_AM_HI:`F_AM_LO];
		con_wr.mode = d[`F_MD_HI:`F_MD_LO];
	endfunction

	// default data address for a source; bit 16 says the pair is valid
	function automatic logic [16:0] src_pad(logic [6:0] q, logic d);
		case (q)
			`SRC_IC1: src_pad = {!d, `PAD_IC1};
			`SRC_U1RX: src_pad = {!d, `PAD_U1RX};
			`SRC_ADC: src_pad = {!d, `PAD_ADC};
			`SRC_OC1: src_pad = {d, `PAD_OC1_PRI};
			`SRC_SPI1: src_pad = {1'b1, `PAD_SPI1};
			`SRC_CODEC: src_pad = {1'b1, d ? `PAD_CODEC_TX : `PAD_CODEC_RX};
			`SRC_CANTX: src_pad = {d, `PAD_CANTX};
			`SRC_DACR: src_pad = {d, `PAD_DACR};
			`SRC_EXT_IRQ0, `SRC_TIMER_TWO, `SRC_TIMER_THREE: src_pad = 17'h00000;
			default: src_pad = 17'h00000;
		endcase
	endfunction

	assign rise = periph_irq_in & ~s_r.irq_prev;
	assign lw = lowest(want);

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.irq = 8'h00;
		s_nxt.irq_prev = periph_irq_in;
		wr_done = 1'b0;
		blk_end = 1'b0;
		frc_set = 1'b0;
		c = wb_adr_in[`A_CH_HI:`A_CH_LO];
		v = 16'h0000;
		a = 16'h0000;
		t = 17'h00000;
		g = s_r.cur;
		k = s_r.ch[s_r.cur];
		for (int i = 0; i < 8; i++) begin
			en_v[i] = s_r.ch[i].con.en;
			pp_v[i] = s_r.ch[i].pp;
			want[i] = s_r.ch[i].con.en && (s_r.ch[i].frc || s_r.ch[i].pend);
		end
		// register slave: one ack per request, dropped the cycle after
		if (wb_cyc_in && wb_stb_in && !s_r.ack) begin
			s_nxt.ack = 1'b1;
			s_nxt.rdat = 32'h00000000;
			if (wb_adr_in[`A_STATUS]) begin
				s_nxt.rdat[15:0] = {pp_v, en_v};
			end else begin
				unique case (wb_adr_in[`A_REG_HI:`A_REG_LO])
					`R_CON: begin
						s_nxt.rdat[15:0] = con_rd(s_r.ch[c].con);
						if (wb_we_in) begin
							v = merge(con_rd(s_r.ch[c].con), wb_dat_in, wb_sel_in);
							s_nxt.ch[c].con = con_wr(v);
							// enabling rearms the channel at buffer A
							if (v[`F_EN] && !s_r.ch[c].con.en) begin
								s_nxt.ch[c].ptr = s_r.ch[c].start_a;
								s_nxt.ch[c].done = 10'h000;
								s_nxt.ch[c].pp = 1'b0;
								s_nxt.ch[c].pend = 1'b0;
							end
						end
					end
					`R_REQ: begin
						s_nxt.rdat[15:0] = {s_r.ch[c].frc, 8'h00, s_r.ch[c].src};
						if (wb_we_in) begin
							v = merge({s_r.ch[c].frc, 8'h00, s_r.ch[c].src}, wb_dat_in, wb_sel_in);
							s_nxt.ch[c].src = v[6:0];
							if (v[`F_FRC]) begin
								frc_set = 1'b1;
								s_nxt.ch[c].frc = 1'b1;
							end
							t = src_pad(v[6:0], s_r.ch[c].con.dir);
							if (t[16]) begin
								s_nxt.ch[c].pad = t[15:0];
							end
						end
					end
					`R_START_A: begin
						s_nxt.rdat[15:0] = s_r.ch[c].ptr;
						if (wb_we_in) begin
							s_nxt.ch[c].start_a = merge(s_r.ch[c].start_a, wb_dat_in, wb_sel_in);
						end
					end
					`R_START_B: begin
						s_nxt.rdat[15:0] = s_r.ch[c].ptr;
						if (wb_we_in) begin
							s_nxt.ch[c].start_b = merge(s_r.ch[c].start_b, wb_dat_in, wb_sel_in);
						end
					end
					`R_PAD: begin
						s_nxt.rdat[15:0] = s_r.ch[c].pad;
						if (wb_we_in) begin
							s_nxt.ch[c].pad = merge(s_r.ch[c].pad, wb_dat_in, wb_sel_in);
						end
					end
					`R_CNT: begin
						s_nxt.rdat[9:0] = s_r.ch[c].cnt;
						if (wb_we_in) begin
							v = merge({6'h00, s_r.ch[c].cnt}, wb_dat_in, wb_sel_in);
							s_nxt.ch[c].cnt = v[9:0];
						end
					end
					default: s_nxt.rdat = 32'h00000000;
				endcase
			end
		end
		// transfer engine on its own bus, cpu never waits on it
		unique case (s_r.st)
			dma_pkg::S_IDLE: begin
				if (|want) begin
					g = lowest(want);
					k = s_r.ch[g];
					a = k.ptr;
					if (k.con.amode[1]) begin
						a = (k.pp ? k.start_b : k.start_a) + periph_ram_ofs_in;
					end
					s_nxt.cur = g;
					s_nxt.ch[g].pend = 1'b0;
					s_nxt.ch[g].ptr = a;
					s_nxt.bus.req = 1'b1;
					s_nxt.bus.we = 1'b0;
					s_nxt.bus.bsz = k.con.bsz;
					s_nxt.bus.ram = k.con.dir;
					s_nxt.bus.adr = k.con.dir ? a : k.pad;
					s_nxt.bus.dat = 16'h0000;
					s_nxt.st = dma_pkg::S_RD;
				end
			end
			dma_pkg::S_RD: begin
				if (dbus_ack_in) begin
					s_nxt.bus.we = 1'b1;
					s_nxt.bus.ram = !k.con.dir;
					s_nxt.bus.adr = k.con.dir ? k.pad : k.ptr;
					s_nxt.bus.dat = k.con.bsz ? {8'h00, dbus_rdata_in[7:0]} : dbus_rdata_in;
					s_nxt.st = dma_pkg::S_WR;
				end
			end
			dma_pkg::S_WR: begin
				if (dbus_ack_in) begin
					wr_done = 1'b1;
					blk_end = k.done == k.cnt;
					s_nxt.bus.req = 1'b0;
					s_nxt.bus.we = 1'b0;
					s_nxt.st = dma_pkg::S_IDLE;
					s_nxt.ch[g].frc = frc_set && c == g;
					s_nxt.ch[g].done = k.done + 10'h001;
					if (k.con.amode == `AM_INC) begin
						s_nxt.ch[g].ptr = k.ptr + (k.con.bsz ? `STEP_BYTE : `STEP_WORD);
					end
					if (k.con.half && k.done == (k.cnt >> 1)) begin
						s_nxt.irq[g] = 1'b1;
					end
					if (blk_end) begin
						s_nxt.ch[g].done = 10'h000;
						s_nxt.irq[g] = !k.con.half;
						s_nxt.ch[g].pp = k.con.mode[1] && !k.pp;
						s_nxt.ch[g].ptr = (k.con.mode[1] && !k.pp) ? k.start_b : k.start_a;
						// one-shot ping-pong ends only after buffer B
						if (k.con.mode[0] && (!k.con.mode[1] || k.pp)) begin
							s_nxt.ch[g].con.en = 1'b0;
						end
					end
				end
			end
			default: s_nxt.st = dma_pkg::S_IDLE;
		endcase
		// a request edge in the grant cycle is kept, set beats clear
		for (int i = 0; i < 8; i++) begin
			if (s_r.ch[i].con.en && !s_r.ch[i].frc && rise[s_r.ch[i].src]) begin
				s_nxt.ch[i].pend = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_r <= '0;
			s_r.st <= dma_pkg::S_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack_out = s_r.ack;
	assign wb_dat_out = s_r.rdat;
	assign dbus_out = s_r.bus;
	assign irq_out = s_r.irq;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	property p_arb;
		s_r.st == dma_pkg::S_IDLE && |want |=> s_r.cur == $past(lw) && s_r.st == dma_pkg::S_RD;
	endproperty
	a_arb: assert property (p_arb) else $error("wrong channel granted");

	property p_hold;
		s_r.bus.req && !dbus_ack_in |=> s_r.bus.req && $stable(s_r.bus.adr) && $stable(s_r.bus.we);
	endproperty
	a_hold: assert property (p_hold) else $error("transfer request dropped before ack");

	property p_frc;
		$fell(s_r.ch[0].frc) |-> $past(wr_done) && $past(s_r.cur) == 3'h0;
	endproperty
	a_frc: assert property (p_frc) else $error("force bit cleared without transfer");

	property p_size;
		s_r.bus.req |-> s_r.bus.bsz == s_r.ch[s_r.cur].con.bsz;
	endproperty
	a_size: assert property (p_size) else $error("bus width differs from channel size");

	property p_dir;
		s_r.st == dma_pkg::S_RD |-> s_r.bus.ram == s_r.ch[s_r.cur].con.dir && !s_r.bus.we;
	endproperty
	a_dir: assert property (p_dir) else $error("read side does not follow direction");

	property p_irq;
		|s_r.irq |-> $past(wr_done) && $onehot(s_r.irq) ##1 s_r.irq == 8'h00;
	endproperty
	a_irq: assert property (p_irq) else $error("completion request not tied to a transfer");

	property p_one;
		wr_done && blk_end && s_r.ch[s_r.cur].con.mode == `MD_ONE |=> !s_r.ch[s_r.cur].con.en;
	endproperty
	a_one: assert property (p_one) else $error("one-shot channel still enabled");

	property p_pp;
		wr_done && blk_end && s_r.ch[s_r.cur].con.mode[1]
			|=> s_r.ch[s_r.cur].pp != $past(s_r.ch[s_r.cur].pp);
	endproperty
	a_pp: assert property (p_pp) else $error("ping-pong buffer not switched");

	property p_fix;
		wr_done && !blk_end && s_r.ch[s_r.cur].con.amode == `AM_FIX |=> $stable(s_r.ch[s_r.cur].ptr);
	endproperty
	a_fix: assert property (p_fix) else $error("fixed address moved");

	c_force: cover property (wr_done && s_r.ch[s_r.cur].frc);
	c_half: cover property (wr_done && s_r.ch[s_r.cur].con.half && |s_nxt.irq);
	c_pp: cover property (wr_done && blk_end && s_r.ch[s_r.cur].con.mode == `MD_ONE_PP);
	c_race: cover property (s_r.st == dma_pkg::S_IDLE && want[0] && want[1]);
endmodule

// ===== tb/dma_far_model.sv
// peripheral data registers and dual port ram answering the transfer bus
`timescale 1ns/100ps
module dma_far_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// transfer bus
	input wire dma_pkg::dbus_t dbus_in,
	input wire logic [1:0] slow_in,
	output logic [15:0] rdata_out,
	output logic ack_out
);
	logic [7:0] ram_m [0:2047];
	logic [7:0] per_m [0:2047];
	logic [15:0] wlog [$];
	logic [15:0] rd_r;
	logic [1:0] wait_r;
	logic [10:0] a;
	assign a = dbus_in.adr[10:0];
	// inverse outside ack, so stale data never looks valid
	assign rdata_out = ack_out ? rd_r : ~rd_r;
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_out <= 1'b0;
			wait_r <= 2'h0;
			rd_r <= 16'h0000;
			for (int i = 0; i < 2048; i++) begin
				ram_m[i] <= 8'(i) ^ 8'hA5;
				per_m[i] <= 8'(i) ^ 8'h5A;
			end
		end else if (ack_out) begin
			ack_out <= 1'b0;
			if (dbus_in.we) begin
				wlog.push_back(dbus_in.adr);
				if (dbus_in.ram) ram_m[a] <= dbus_in.dat[7:0];
				else per_m[a] <= dbus_in.dat[7:0];
				if (!dbus_in.bsz && dbus_in.ram) ram_m[a + 11'h001] <= dbus_in.dat[15:8];
				if (!dbus_in.bsz && !dbus_in.ram) per_m[a + 11'h001] <= dbus_in.dat[15:8];
			end
		end else if (dbus_in.req && wait_r == slow_in) begin
			ack_out <= 1'b1;
			wait_r <= 2'h0;
			if (dbus_in.ram) rd_r <= {dbus_in.bsz ? 8'h00 : ram_m[a + 11'h001], ram_m[a]};
			else rd_r <= {dbus_in.bsz ? 8'h00 : per_m[a + 11'h001], per_m[a]};
		end else if (dbus_in.req) begin
			wait_r <= wait_r + 2'h1;
		end
	end
endmodule

// ===== tb/periph_dma_tb_top.sv
// register, force, priority and ping-pong sequences for the dma controller
`timescale 1ns/100ps
module periph_dma_tb_top;
	logic clk_in = 1'b0, rstn_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, mack;
	logic [8:0] adr = 9'h000;
	logic [31:0] wdat = 32'h00000000, wb_dat_out;
	logic [127:0] pirq = 128'h0;
	logic [15:0] ofs = 16'h0040, rd, mrd;
	logic [1:0] slow = 2'h0;
	logic wb_ack_out;
	logic [7:0] irq_out;
	dma_pkg::dbus_t dbus_out;
	int err_total = 0, num_checks = 0;
	int icnt [8];
	logic [6:0] ts [7] = '{7'h02, 7'h02, 7'h3C, 7'h3C, 7'h46, 7'h4E, 7'h01};
	logic [15:0] tc [7] = '{16'h2000, 16'h0000, 16'h0000, 16'h2000, 16'h2000, 16'h2000, 16'h0000};
	logic [15:0] tp [7] = '{16'h0182, 16'h0000, 16'h0290, 16'h0298, 16'h0442, 16'h03F6, 16'h0140};
	logic [15:0] pw [5] = '{16'h0100, 16'h0102, 16'h0200, 16'h0202, 16'h0100};
	always #10 clk_in = ~clk_in;
	always @(posedge clk_in) for (int i = 0; i < 8; i++) if (irq_out[i] === 1'b1) icnt[i]++;
	periph_dma i_periph_dma (.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(4'h3), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.periph_irq_in(pirq), .periph_ram_ofs_in(ofs), .dbus_out(dbus_out), .dbus_rdata_in(mrd),
		.dbus_ack_in(mack), .irq_out(irq_out));
	dma_far_model i_dma_far_model (.clk_in(clk_in), .rstn_in(rstn_in), .dbus_in(dbus_out), .slow_in(slow),
		.rdata_out(mrd), .ack_out(mack));
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one classic cycle; ch 8 reaches the common status word
	task automatic wb(input logic w, input int ch, input int rg, input logic [15:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= 9'(ch * 32 + rg * 4);
		wdat <= {16'h0000, d};
		// only the watchdog ends a wait for ack
		do begin
			@(posedge clk_in);
		end while (wb_ack_out !== 1'b1);
		rd = wb_dat_out[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_in);
	endtask
	// setup: con without enable, req, sta, stb, cnt, then enable
	task automatic setup(input int ch, input logic [15:0] c, input logic [15:0] q, input logic [15:0] sa,
		input logic [15:0] sb, input logic [15:0] n);
		wb(1'b1, ch, 0, c);
		wb(1'b1, ch, 1, q);
		wb(1'b1, ch, 2, sa);
		wb(1'b1, ch, 3, sb);
		wb(1'b1, ch, 5, n);
		wb(1'b1, ch, 0, c | 16'h8000);
	endtask
	task automatic idle();
		int q, n;
		q = 0;
		n = 0;
		while (q < 8 && n < 300) begin
			@(posedge clk_in);
			n++;
			q = (dbus_out.req === 1'b1) ? 0 : q + 1;
		end
	endtask
	task automatic pulse(input int b);
		pirq[b] <= 1'b1;
		repeat (2) @(posedge clk_in);
		pirq[b] <= 1'b0;
		idle();
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		wb(1'b0, 7, 0, 16'h0000);
		chk("con7", rd, 16'h0000);
		wb(1'b1, 0, 6, 16'h1234);
		wb(1'b0, 0, 6, 16'h0000);
		chk("unmapped", rd, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			wb(1'b1, 7, 0, tc[i]);
			wb(1'b1, 7, 1, {9'h000, ts[i]});
			if (i == 1) wb(1'b1, 7, 4, 16'h0180);
			wb(1'b0, 7, 4, 16'h0000);
			chk("pad", rd, i == 1 ? 16'h0180 : tp[i]);
		end
		$display("test source table done");
		setup(0, 16'h0001, 16'h000B, 16'h0010, 16'h0000, 16'h0003);
		for (int k = 1; k <= 4; k++) begin
			pulse(11);
			chk("irq0", 16'(icnt[0]), k == 4 ? 16'h0001 : 16'h0000);
			wb(1'b0, 0, 2, 16'h0000);
			chk("ptr0 live", rd, k == 4 ? 16'h0010 : 16'h0010 + 16'(2 * k));
		end
		chk("ram16", {i_dma_far_model.ram_m[23], i_dma_far_model.ram_m[22]}, 16'h7D7C);
		chk("ram18", {8'h00, i_dma_far_model.ram_m[24]}, 16'h00BD);
		wb(1'b0, 0, 2, 16'h0000);
		chk("ptr0", rd, 16'h0010);
		wb(1'b0, 8, 0, 16'h0000);
		chk("oneshot", rd, 16'h0000);
		$display("test increment block done");
		setup(1, 16'h6011, 16'h000A, 16'h0020, 16'h0000, 16'h0000);
		wb(1'b1, 1, 1, 16'h800A);
		idle();
		chk("per248", {i_dma_far_model.per_m[585], i_dma_far_model.per_m[584]}, 16'h1385);
		wb(1'b0, 1, 1, 16'h0000);
		chk("force", rd, 16'h000A);
		chk("irq1", 16'(icnt[1]), 16'h0001);
		$display("test force done");
		setup(3, 16'h0021, 16'h0007, 16'h0300, 16'h0000, 16'h0000);
		setup(2, 16'h0011, 16'h0007, 16'h0400, 16'h0000, 16'h0001);
		wb(1'b1, 2, 4, 16'h0140);
		wb(1'b1, 3, 4, 16'h0300);
		i_dma_far_model.wlog.delete();
		pulse(7);
		chk("first", i_dma_far_model.wlog[0], 16'h0400);
		chk("second", i_dma_far_model.wlog[1], 16'h0340);
		pulse(7);
		chk("fixed", i_dma_far_model.wlog[2], 16'h0400);
		$display("test priority done");
		slow <= 2'h2;
		setup(4, 16'h1002, 16'h000D, 16'h0100, 16'h0200, 16'h0001);
		i_dma_far_model.wlog.delete();
		for (int k = 1; k <= 5; k++) begin
			pulse(13);
			chk("irq4", 16'(icnt[4]), 16'((k + 1) / 2));
			chk("pp", i_dma_far_model.wlog[k - 1], pw[k - 1]);
		end
		// one-shot ping-pong: buffer a, then buffer b, then stop
		setup(5, 16'h0003, 16'h0001, 16'h0500, 16'h0600, 16'h0000);
		i_dma_far_model.wlog.delete();
		pulse(1);
		wb(1'b0, 8, 0, 16'h0000);
		chk("pp5", rd, 16'h2030);
		pulse(1);
		chk("a5", i_dma_far_model.wlog[0], 16'h0500);
		chk("b5", i_dma_far_model.wlog[1], 16'h0600);
		chk("irq5", 16'(icnt[5]), 16'h0002);
		wb(1'b0, 8, 0, 16'h0000);
		chk("status", rd, 16'h0010);
		$display("test ping-pong done");
		print_verdict();
	end
endmodule
